// [verilog/fsc_pkg.sv]
// Purpose: Shared constants and types of the store format converter.
// Assumes: Double format is IEEE-754 binary64, single format binary32.
// Notes:   Offsets are bit positions inside the 64-bit register image.
package fsc_pkg;

    // Register image fields
    localparam int SIGN_POS     = 63;
    localparam int EXP_HI       = 62;
    localparam int EXP_LO       = 52;
    localparam int FRAC_HI      = 51;
    localparam int SFRAC_LO     = 29;   // Lowest fraction bit kept in single format

    // Exponent limits
    localparam logic [10:0] EXP_ZERO      = 11'h000;
    localparam logic [10:0] EXP_ALL_ONES  = 11'h7FF;
    localparam logic [10:0] EXP_DENORM_MAX = 11'd896;  // Highest double exponent that denormalizes
    localparam logic [11:0] EXP_SNG_MIN   = 12'd897;   // Double exponent of single minimum normal

    // Shifter sizing
    localparam int          MANT_W        = 24;        // Hidden bit plus 23 fraction bits
    localparam int          CNT_W         = 5;
    localparam logic [4:0]  SHIFT_MAX     = 5'd23;

    // Values after reset
    localparam logic [63:0] DATA_RST      = 64'h0000_0000_0000_0000;
    localparam logic [23:0] MANT_RST      = 24'h00_0000;
    localparam logic [4:0]  CNT_RST       = 5'h00;

    // Converter sequence states
    typedef enum logic [0:0] {
        FSC_ST_IDLE  = 1'b0,
        FSC_ST_SHIFT = 1'b1
    } fsc_state_t;

endpackage : fsc_pkg

// [verilog/fsc_shift_if.sv]
// Purpose: Carrier between the converter control and its mantissa shifter.
// Assumes: One clock domain; load is a one-cycle pulse.
// Notes:   ctl drives the request, eng returns the shifted mantissa.
`timescale 1ns/1ns
interface fsc_shift_if;
    logic        load;
    logic        left;
    logic [4:0]  count;
    logic [23:0] value;
    logic [23:0] mant;
    logic        busy;
    logic        done;

    modport ctl (output load, output left, output count, output value,
                 input mant, input busy, input done);
    modport eng (input load, input left, input count, input value,
                 output mant, output busy, output done);
endinterface : fsc_shift_if

// [verilog/fsc_shifter.sv]
// Purpose: Bit-serial mantissa shifter, one bit position per clock.
// Assumes: count is 1 to 23 when load is pulsed.
// Notes:   The load edge already makes the first shift, so done pulses
//          right after the edge of the last shift with mant final.
`timescale 1ns/1ns
module fsc_shifter (
    input  wire logic  ref_clk,
    input  wire logic  arst_n,
    fsc_shift_if.eng   sh
);

    typedef struct packed {
        logic [23:0] mant;
        logic [4:0]  cnt;
        logic        left;
        logic        busy;
        logic        done;
    } fsc_shift_st_t;

    fsc_shift_st_t st_reg;
    fsc_shift_st_t st_next;

    // One position per cycle until the count runs out
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (sh.load) begin
            // First position moves on the load edge itself
            st_next.mant = sh.left ? {sh.value[22:0], 1'b0}
                                   : {1'b0, sh.value[23:1]};
            st_next.cnt  = sh.count - 5'd1;
            st_next.left = sh.left;
            st_next.busy = (sh.count != 5'd1);
            st_next.done = (sh.count == 5'd1);
        end else if (st_reg.busy) begin
            st_next.mant = st_reg.left ? {st_reg.mant[22:0], 1'b0}
                                       : {1'b0, st_reg.mant[23:1]};
            st_next.cnt  = st_reg.cnt - 5'd1;
            if (st_reg.cnt == 5'd1) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{mant: fsc_pkg::MANT_RST, cnt: fsc_pkg::CNT_RST,
                        left: 1'b0, busy: 1'b0, done: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sh.mant = st_reg.mant;
    assign sh.busy = st_reg.busy;
    assign sh.done = st_reg.done;

endmodule : fsc_shifter

// [verilog/fsc_store_conv.sv]
// Purpose: Store format converter between the FP register file and memory.
// Assumes: Register image is double format plus a precision tag; single
//          denormals are held tag single, exponent zero, fraction in 51:29.
// Notes:   One request at a time; result is a one-cycle pulse, no stall.
// Contract
// - Store path always starts from a double-format register value.
// - Single stores narrow the register value to a 32-bit word.
// - Normalized double with exponent 874 to 896 is denormalized, below 874 stored as signed zero, else stored.
// - Denormalization shifts one bit per clock, taking 1 to 23 cycles.
// - Double store of single denormal normalizes, 1 to 23 extra cycles.
// - All other double-store operands pass unchanged with no extra delay.
`timescale 1ns/1ns
module fsc_store_conv (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_single,
    input  wire logic        req_tag_single,
    input  wire logic [63:0] req_data,
    output logic             res_valid,
    output logic             res_single,
    output logic [63:0]      res_data
);

    typedef struct packed {
        fsc_pkg::fsc_state_t state;
        logic                sgn;
        logic                single_op;
        logic [10:0]         exp_base;
        logic                res_valid;
        logic                res_single;
        logic [63:0]         res_data;
    } fsc_conv_st_t;

    fsc_conv_st_t st_reg;
    fsc_conv_st_t st_next;

    fsc_shift_if sh ();

    fsc_shifter u_shift (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .sh      (sh)
    );

    logic        in_sgn;
    logic [10:0] in_exp;
    logic [51:0] in_frac;
    logic [22:0] in_sfrac;
    logic        frac_nz;
    logic        dbl_norm;
    logic        dbl_denorm;
    logic        sng_denorm;
    logic [11:0] dn_dist;
    logic [4:0]  nm_dist;
    logic [31:0] word_direct;

    // Split the register image into its fields
    always_comb begin
        in_sgn   = req_data[fsc_pkg::SIGN_POS];
        in_exp   = req_data[fsc_pkg::EXP_HI:fsc_pkg::EXP_LO];
        in_frac  = req_data[fsc_pkg::FRAC_HI:0];
        in_sfrac = req_data[fsc_pkg::FRAC_HI:fsc_pkg::SFRAC_LO];
        frac_nz  = (in_frac != 52'h0_0000_0000_0000);
        dbl_norm   = !req_tag_single && (in_exp != fsc_pkg::EXP_ZERO)
                     && (in_exp != fsc_pkg::EXP_ALL_ONES);
        dbl_denorm = !req_tag_single && (in_exp == fsc_pkg::EXP_ZERO) && frac_nz;
        sng_denorm = req_tag_single && (in_exp == fsc_pkg::EXP_ZERO) && frac_nz;
    end

    // Shift distances for both directions
    always_comb begin
        dn_dist = fsc_pkg::EXP_SNG_MIN - {1'b0, in_exp};
        nm_dist = fsc_pkg::SHIFT_MAX;
        for (int i = 0; i < 23; i++) begin
            if (in_sfrac[i]) begin
                nm_dist = 5'(23 - i);   // Leading one up to the hidden bit
            end
        end
    end

    assign word_direct = {req_data[63:62], req_data[58:fsc_pkg::SFRAC_LO]};

    // Sequence and result forming
    always_comb begin
        st_next           = st_reg;
        st_next.res_valid = 1'b0;
        sh.load           = 1'b0;
        sh.left           = 1'b0;
        sh.count          = fsc_pkg::CNT_RST;
        sh.value          = fsc_pkg::MANT_RST;
        case (st_reg.state)
            fsc_pkg::FSC_ST_IDLE: begin
                if (req_valid) begin
                    st_next.sgn        = in_sgn;
                    st_next.single_op  = req_single;
                    st_next.exp_base   = in_exp;
                    st_next.res_single = req_single;
                    if (req_single) begin
                        if (dbl_norm && (in_exp <= fsc_pkg::EXP_DENORM_MAX)) begin
                            if (dn_dist > {7'h00, fsc_pkg::SHIFT_MAX}) begin
                                // Too small for single format, truncates to zero
                                st_next.res_data  = {32'h0000_0000, in_sgn, 31'h0000_0000};
                                st_next.res_valid = 1'b1;
                            end else begin
                                sh.load       = 1'b1;
                                sh.left       = 1'b0;
                                sh.count      = dn_dist[4:0];
                                sh.value      = {1'b1, in_sfrac};
                                st_next.state = fsc_pkg::FSC_ST_SHIFT;
                            end
                        end else if (dbl_denorm) begin
                            st_next.res_data  = {32'h0000_0000, in_sgn, 31'h0000_0000};
                            st_next.res_valid = 1'b1;
                        end else begin
                            st_next.res_data  = {32'h0000_0000, word_direct};
                            st_next.res_valid = 1'b1;
                        end
                    end else if (sng_denorm) begin
                        sh.load       = 1'b1;
                        sh.left       = 1'b1;
                        sh.count      = nm_dist;
                        sh.value      = {1'b0, in_sfrac};
                        st_next.exp_base = 11'(fsc_pkg::EXP_SNG_MIN - {7'h00, nm_dist});
                        st_next.state = fsc_pkg::FSC_ST_SHIFT;
                    end else begin
                        st_next.res_data  = req_data;
                        st_next.res_valid = 1'b1;
                    end
                end
            end
            fsc_pkg::FSC_ST_SHIFT: begin
                if (sh.done) begin
                    st_next.state     = fsc_pkg::FSC_ST_IDLE;
                    st_next.res_valid = 1'b1;
                    if (st_reg.single_op) begin
                        st_next.res_data = {32'h0000_0000, st_reg.sgn, 8'h00, sh.mant[22:0]};
                    end else begin
                        st_next.res_data = {st_reg.sgn, st_reg.exp_base,
                                            sh.mant[22:0], 29'h0000_0000};
                    end
                end
            end
            default: begin
                st_next.state = fsc_pkg::FSC_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{state: fsc_pkg::FSC_ST_IDLE, sgn: 1'b0, single_op: 1'b0,
                        exp_base: fsc_pkg::EXP_ZERO, res_valid: 1'b0,
                        res_single: 1'b0, res_data: fsc_pkg::DATA_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign req_ready  = (st_reg.state == fsc_pkg::FSC_ST_IDLE);
    assign res_valid  = st_reg.res_valid;
    assign res_single = st_reg.res_single;
    assign res_data   = st_reg.res_data;

endmodule : fsc_store_conv

// [test/fsc_store_conv_checker.sv]
// Purpose: Port-level assertions for the store format converter.
// Assumes: One clock domain, reset asynchronous active low.
// Notes:   Latencies follow the direct and shifting cases.
`timescale 1ns/1ns
module fsc_store_conv_checker (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_single,
    input wire logic        req_tag_single,
    input wire logic [63:0] req_data,
    input wire logic        res_valid,
    input wire logic        res_single,
    input wire logic [63:0] res_data
);
    logic [10:0] e;
    logic        acc;
    logic        sd;
    logic        dd;
    // Request decode helpers
    assign e   = req_data[62:52];
    assign acc = req_valid && req_ready;
    assign sd  = acc && req_single && !req_tag_single;
    assign dd  = acc && !req_single && req_tag_single && e == 11'h000 && req_data[51:29] != 23'h0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    AST_PASS: assert property (acc && !req_single && !dd |=>
        res_valid && !res_single && res_data == $past(req_data)) else $error("double store altered");
    AST_SGL_WORD: assert property (acc && req_single |-> ##[1:24]
        (res_valid && res_single && res_data[63:32] == 32'h0)) else $error("single word missing");
    AST_HOLD: assert property (!res_valid |-> $stable(res_data))
        else $error("result changed without valid");
    AST_SGL_NORM: assert property (sd && e > 11'd896 && e != 11'h7FF |=> res_valid &&
        res_data[31:0] == {$past(req_data[63:62]), $past(req_data[58:29])}) else $error("narrow bad");
    AST_DEN_ZERO: assert property (sd && e == 11'h000 && req_data[51:0] != 52'h0 |=>
        res_valid && res_data == {32'h0, $past(req_data[63]), 31'h0}) else $error("not zero");
    AST_SHIFT_ONE: assert property (sd && e == 11'd896 |=>
        !res_valid && !req_ready ##1 res_valid) else $error("one shift timing");
    AST_SHIFT_BUSY: assert property (sd && e >= 11'd874 && e <= 11'd896 |=> !req_ready)
        else $error("ready while shifting");
    AST_SHIFT_MAX: assert property (sd && e == 11'd874 |-> ##24 res_valid)
        else $error("long shift timing");
    AST_NORM: assert property (dd |-> ##[2:24] (res_valid && res_data[62:52] >= 11'd874 &&
        res_data[28:0] == 29'h0)) else $error("normalize bad");
endmodule : fsc_store_conv_checker

bind fsc_store_conv fsc_store_conv_checker fsc_store_conv_checker_inst (.ref_clk, .arst_n,
    .req_valid, .req_ready, .req_single, .req_tag_single, .req_data, .res_valid,
    .res_single, .res_data);

// [test/fsc_store_sink.sv]
// Purpose: Memory store path model that keeps the last stored word.
// Assumes: Results arrive as one-cycle pulses, never stalled.
// Notes:   No back-pressure offered.
`timescale 1ns/1ns
module fsc_store_sink (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        res_valid,
    input  wire logic [63:0] res_data,
    output logic [63:0]      stored_data
);
    // Capture on each store pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) stored_data <= 64'h0;
        else if (res_valid) stored_data <= res_data;
    end
endmodule : fsc_store_sink

// [test/test_fp_store_format_converter.sv]
// Purpose: Self-checking bench of the store format converter.
// Assumes: Reference function mirrors the conversion table.
// Notes:   Corner values first, then random stores.
`timescale 1ns/1ns
module test_fp_store_format_converter;
    logic        ref_clk, arst_n, req_valid, req_single, req_tag_single;
    logic        req_ready, res_valid, res_single;
    logic [63:0] req_data, res_data, stored_data, d;
    logic [31:0] seed;
    int          failures, total_checks, elat;
    logic [10:0] ce [8] = '{11'd896, 11'd874, 11'd873, 11'd897, 11'h0, 11'h7FF, 11'd1150, 11'd885};
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    fsc_store_conv fsc_store_conv_inst (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_single(req_single), .req_tag_single(req_tag_single),
        .req_data(req_data), .res_valid(res_valid), .res_single(res_single), .res_data(res_data));
    fsc_store_sink fsc_store_sink_inst (.ref_clk(ref_clk), .arst_n(arst_n), .res_valid(res_valid),
        .res_data(res_data), .stored_data(stored_data));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Expected word, latency left in elat
    function automatic logic [63:0] expect_f(input logic s, input logic t, input logic [63:0] v);
        logic [10:0] e;
        logic [23:0] m;
        int          n;
        e = v[62:52];
        m = {1'b1, v[51:29]};
        n = 0;
        elat = 1;
        if (s && !t && e == 11'h0 && v[51:0] != 52'h0) return {32'h0, v[63], 31'h0};
        if (s && !t && e != 11'h0 && e <= 11'd896) begin
            n = 897 - int'(e);
            if (n > 23) return {32'h0, v[63], 31'h0};
            elat = n + 1;
            m = m >> n;
            return {32'h0, v[63], 8'h00, m[22:0]};
        end
        if (s) return {32'h0, v[63:62], v[58:29]};
        if (!t || e != 11'h0 || v[51:29] == 23'h0) return v;
        m = {1'b0, v[51:29]};
        while (!m[23]) begin
            m = m << 1;
            n++;
        end
        elat = n + 1;
        return {v[63], 11'(897 - n), m[22:0], 29'h0};
    endfunction : expect_f
    task chk(input logic [63:0] got, input logic [63:0] want);
        total_checks++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // One store; junk offered while busy must be refused
    task go(input logic s, input logic t, input logic [63:0] v);
        logic [63:0] w;
        int          lat;
        w = expect_f(s, t, v);
        lat = 1;
        req_valid = 1'b1;
        req_single = s;
        req_tag_single = t;
        req_data = v;
        @(posedge ref_clk);
        #1;
        if (elat > 1) req_data = ~v;
        while (res_valid !== 1'b1 && lat < 30) begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
        req_valid = 1'b0;
        chk(res_data, w);
        chk(64'(res_single), 64'(s));
        chk(64'(lat), 64'(elat));
        @(posedge ref_clk);
        #1;
        chk(stored_data, w);
    endtask : go
    // Main sequence
    initial begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_single = 1'b0;
        req_tag_single = 1'b0;
        req_data = 64'h0;
        seed = 32'h20A8A158;
        failures = 0;
        total_checks = 0;
        repeat (2) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 8; i++) go(1'b1, 1'b0, {1'b1, ce[i], 52'hA_BCDE_F012_3456});
        go(1'b0, 1'b1, {1'b0, 11'h0, 23'h40_0000, 29'h0});
        go(1'b0, 1'b1, {1'b1, 11'h0, 23'h00_0001, 29'h0});
        go(1'b0, 1'b0, {1'b0, 11'h0, 52'h1});
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            d[63:32] = seed;
            seed = lfsr(seed);
            d[31:0] = seed;
            if (seed[3]) d[62:52] = 11'd870 + 11'(seed[8:4]);
            if (seed[9]) d[28:0] = 29'h0;
            if (seed[9] && seed[10]) d[62:52] = 11'h0;
            go(seed[11], seed[9], d);
        end
        req_valid = 1'b0;
        repeat (2) @(posedge ref_clk);
        final_report;
    end
    // Watchdog
    initial begin
        #200000;
        failures++;
        final_report;
    end
endmodule : test_fp_store_format_converter
